// *** cmcr_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cmcr_consts.vh"
// ---------------------------------------------------------------
// charger power-path control register
// ---------------------------------------------------------------
module cmcr_ctrl #(
    parameter [31:0] WD_PERIOD = `CMCR_WD_PERIOD_NS / `CMCR_CLK_NS
) (
    input wire clock_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire battery_switch_disable_pin_i,
    input wire resistor_fault_i,
    input wire input_valid_i,
    input wire path_switch_on_i,
    input wire path_converter_on_i,
    output reg [7:0] rdata_o,
    output reg programming_source_select_o,
    output reg charger_suspended_o,
    output reg charger_restart_o,
    output reg charger_on_o,
    output reg converter_on_o,
    output reg otg_on_o,
    output reg battery_switch_on_o,
    output reg input_standby_o,
    output reg watchdog_expired_o
);
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    reg src;
    reg dis_cmd;
    reg stby_cmd;
    reg wden;
    reg [3:0] mode_cmd;
    wire pin_sync;
    wire wd_exp;

    // ---------------------------------------------------------------
    // access decode
    // ---------------------------------------------------------------
    // an access only counts when its address matches; all others are refused
    wire hit_ctrl = (addr_i == `CMCR_ADDR_CTRL);
    wire hit_clr = (addr_i == `CMCR_ADDR_WDCLR);
    wire wr_ctrl = wr_en_i && hit_ctrl;
    wire rd_ctrl = rd_en_i && hit_ctrl;
    // only the one clear code restarts the watchdog, so a stray write cannot
    wire wr_clr = wr_en_i && hit_clr && (wdata_i == `CMCR_WDCLR_CODE);

    // write-data fields of the control register
    wire wr_src = wdata_i[`CMCR_BIT_SRC];
    wire wr_dis = wdata_i[`CMCR_BIT_DIS];
    wire wr_stby = wdata_i[`CMCR_BIT_STBY];
    wire wr_wden = wdata_i[`CMCR_BIT_WDEN];
    wire [3:0] wr_mode = wdata_i[`CMCR_MODE_MSB:`CMCR_MODE_LSB];
    // the source bit is only ever raised, and only by a write carrying a 1
    wire src_set = wr_ctrl && wr_src;

    // ---------------------------------------------------------------
    // pin synchroniser and watchdog
    // ---------------------------------------------------------------
    // the pin is asynchronous to this clock, so it costs two cycles of lag
    cmcr_sync u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(battery_switch_disable_pin_i),
        .q_o(pin_sync)
    );

    // the watchdog only runs while the enable bit is set
    cmcr_wdog #(.PERIOD(WD_PERIOD)) u_wdog (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(wden),
        .clear_i(wr_clr),
        .expired_o(wd_exp)
    );

    // ---------------------------------------------------------------
    // control register bits
    // ---------------------------------------------------------------
    // each field has its own process so that its write rule stands alone
    // source bit is sticky: a written 0 is ignored, so once set it stays set
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            src <= `CMCR_RST_FLAG;
        else if (src_set)
            src <= 1'b1;
    end

    // switch disable as commanded; the pin is merged in further down
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            dis_cmd <= `CMCR_RST_FLAG;
        else if (wr_ctrl)
            dis_cmd <= wr_dis;
    end

    // standby command; forces the converter off while set
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            stby_cmd <= `CMCR_RST_FLAG;
        else if (wr_ctrl)
            stby_cmd <= wr_stby;
    end

    // watchdog enable; clearing it also drops a pending expiry
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            wden <= `CMCR_RST_FLAG;
        else if (wr_ctrl)
            wden <= wr_wden;
    end

    // mode field; reserved codes are stored as written and decode as no mode: paths off, switch left to the path machine
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            mode_cmd <= `CMCR_RST_MODE;
        else if (wr_ctrl)
            mode_cmd <= wr_mode;
    end

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    reg [3:0] eff_mode;
    // an expired watchdog overrides the written mode, and the readback
    // shows the override, so the host can see why charging stopped
    always @*
    begin
        eff_mode = mode_cmd;
        if (wd_exp)
            eff_mode = `CMCR_MODE_OFF;
    end

    // one flag per class of mode; reserved codes match none: paths off, battery switch follows the path machine
    wire mode_off = (eff_mode <= `CMCR_MODE_OFF_MAX);
    wire mode_conv = (eff_mode == `CMCR_MODE_CONV);
    wire mode_chg = (eff_mode > `CMCR_MODE_CONV) && (eff_mode <= `CMCR_MODE_CHG_MAX);
    wire mode_otg = (eff_mode == `CMCR_MODE_OTG);
    // the pin and the command both disable the switch, either one suffices
    wire eff_dis = dis_cmd | pin_sync;

    // ---------------------------------------------------------------
    // power-path requests
    // ---------------------------------------------------------------
    // requests settle here and are registered below, one cycle behind
    reg next_chg;
    reg next_conv;
    reg next_otg;
    reg next_sw;
    // standby and the disable override come last so that they beat any mode
    always @*
    begin
        next_chg = 1'b0;
        next_conv = 1'b0;
        next_otg = 1'b0;
        next_sw = path_switch_on_i;
        if (mode_off)
            next_sw = 1'b1;
        if (mode_conv)
            next_conv = input_valid_i & path_converter_on_i;
        if (mode_chg)
        begin
            next_conv = input_valid_i & path_converter_on_i;
            next_chg = input_valid_i & ~charger_suspended_o;
        end
        if (mode_otg)
        begin
            next_otg = 1'b1;
            next_sw = 1'b1;
        end
        if (stby_cmd)
        begin
            next_conv = 1'b0;
            next_chg = 1'b0;
            next_otg = 1'b0;
        end
        if (eff_dis)
            next_sw = 1'b0;
    end

    // readback word: each field shows the state in force, not the last write;
    // the mode field thus reads 0 after an expiry whatever was written
    wire [7:0] rd_word = {src, eff_dis, stby_cmd, wden, eff_mode};

    // ---------------------------------------------------------------
    // outputs and readback
    // ---------------------------------------------------------------
    // read data stand one cycle after the strobe and are zero otherwise,
    // so an unmapped address never echoes an older word
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_ctrl)
            rdata_o <= rd_word;
        else
            rdata_o <= 8'h00;
    end

    // source select as seen by the settings logic
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            programming_source_select_o <= 1'b0;
        else
            programming_source_select_o <= src;
    end

    // a resistor fault suspends charging while the resistors set the limits;
    // a fault in the cycle of the source write wins, and the now sticky
    // source clears the flag one cycle later, so the flag cannot lock up
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            charger_suspended_o <= 1'b0;
        else if (resistor_fault_i && !src)
            charger_suspended_o <= 1'b1;
        else if (src || src_set)
            charger_suspended_o <= 1'b0;
    end

    // restart pulses once, on the write that lifts a suspension; a later
    // write of the source bit finds it already set and stays quiet
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            charger_restart_o <= 1'b0;
        else
            charger_restart_o <= src_set && !src && charger_suspended_o;
    end

    // charger enable; a suspension or standby holds it off even in a
    // charging mode
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            charger_on_o <= 1'b0;
        else
            charger_on_o <= next_chg;
    end

    // converter enable; follows the path machine only in modes that allow it,
    // so a path request alone never starts the converter
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            converter_on_o <= 1'b0;
        else
            converter_on_o <= next_conv;
    end

    // reverse buck enable; it never overlaps charging because only one
    // mode class can be active at a time
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            otg_on_o <= 1'b0;
        else
            otg_on_o <= next_otg;
    end

    // battery switch; it starts off out of reset and a disable beats
    // every mode, otg included, at the cost of leaving the rail unsupported
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            battery_switch_on_o <= 1'b0;
        else
            battery_switch_on_o <= next_sw;
    end

    // standby in force; it mirrors the command because nothing else
    // in this block can force standby
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            input_standby_o <= 1'b0;
        else
            input_standby_o <= stby_cmd;
    end

    // watchdog expiry; registered so the output comes from a flip-flop
    // like all the others, one cycle after the counter runs out
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            watchdog_expired_o <= 1'b0;
        else
            watchdog_expired_o <= wd_exp;
    end
endmodule // cmcr_ctrl
`default_nettype wire

// *** cmcr_consts.vh ***
// Operation
// - source bit 7 at 0 selects resistor programming; writing 0 does nothing
// - writing 1 to source bit selects serial-bus programming of the settings
// - setting source bit clears resistor-fault suspension and restarts charging
// - bit 6 at 1 forces battery switch off, else modes 0x0-0x3 and 0xa turn it on and path logic controls it in the rest
// - switch-disable readback is the written command or the disable pin
// - bit 5 at 1 forces converter off and enters input standby
// - standby readback shows the standby setting actually in force
// - bit 4 enables the watchdog; expiry stops normal charger operation
// - mode 0x0-0x3 all off; battery feeds system when switch allowed
// - mode 0x4 converter on, charger and otg off
// - modes 0x5-0x7 charger and converter on, otg off
// - mode 0xa otg reverse buck on, charger off, battery switch on
// - mode readback returns the configuration actually in effect
// - reset: control bits zero, mode field 0x5
`ifndef CMCR_CONSTS_VH
`define CMCR_CONSTS_VH
`define CMCR_ADDR_CTRL 8'h16
`define CMCR_ADDR_WDCLR 8'h17
`define CMCR_WDCLR_CODE 8'h01
`define CMCR_BIT_SRC 7
`define CMCR_BIT_DIS 6
`define CMCR_BIT_STBY 5
`define CMCR_BIT_WDEN 4
`define CMCR_MODE_MSB 3
`define CMCR_MODE_LSB 0
`define CMCR_RST_FLAG 1'b0
`define CMCR_RST_MODE 4'h5
`define CMCR_MODE_OFF 4'h0
`define CMCR_MODE_OFF_MAX 4'h3
`define CMCR_MODE_CONV 4'h4
`define CMCR_MODE_CHG_MAX 4'h7
`define CMCR_MODE_OTG 4'ha
`define CMCR_WD_PERIOD_NS 32'd80000000
`define CMCR_CLK_NS 32'd40
`endif

// *** cmcr_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the external disable pin
module cmcr_sync (
    input wire clock_i,
    input wire rst_i,
    input wire d_i,
    output reg q_o
);
    reg meta;
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // cmcr_sync
`default_nettype wire

// *** cmcr_wdog.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cmcr_consts.vh"
// watchdog: counts while enabled, restarts on clear, flags expiry
module cmcr_wdog #(
    parameter [31:0] PERIOD = `CMCR_WD_PERIOD_NS / `CMCR_CLK_NS
) (
    input wire clock_i,
    input wire rst_i,
    input wire enable_i,
    input wire clear_i,
    output reg expired_o
);
    reg [31:0] count;
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count <= 32'h0;
            expired_o <= 1'b0;
        end
        else if (!enable_i || clear_i)
        begin
            count <= 32'h0;
            expired_o <= 1'b0;
        end
        else if (count >= PERIOD - 32'h1)
            expired_o <= 1'b1;
        else
            count <= count + 32'h1;
    end
endmodule // cmcr_wdog
`default_nettype wire

// *** cmcr_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// --
// register checks
// --
module cmcr_ctrl_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic battery_switch_disable_pin_i,
    input wire logic [7:0] rdata_o,
    input wire logic programming_source_select_o,
    input wire logic charger_suspended_o,
    input wire logic charger_restart_o,
    input wire logic charger_on_o,
    input wire logic converter_on_o,
    input wire logic otg_on_o,
    input wire logic battery_switch_on_o,
    input wire logic input_standby_o
);
// one domain, so one clocking for all
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
a_src_sticky: assert property (programming_source_select_o |=> programming_source_select_o)
    else $error("source select fell");
a_src_write: assert property (wr_en_i && addr_i == 8'h16 && wdata_i[7] |-> ##[1:2] programming_source_select_o)
    else $error("source select not set");
a_restart_pulse: assert property (charger_restart_o |=> !charger_restart_o)
    else $error("restart longer than one cycle");
a_susp_cleared: assert property (programming_source_select_o [*3] |-> !charger_suspended_o)
    else $error("suspension kept");
a_pin_off: assert property (battery_switch_disable_pin_i [*5] |-> !battery_switch_on_o)
    else $error("switch on while pin disables");
a_pin_read: assert property (battery_switch_disable_pin_i [*4] ##0 rd_en_i && addr_i == 8'h16 |=> rdata_o[6])
    else $error("disable readback low");
a_stby_conv: assert property (input_standby_o |-> !converter_on_o)
    else $error("converter on in standby");
a_otg_excl: assert property (otg_on_o |-> !charger_on_o)
    else $error("charger and otg both on");
endmodule // cmcr_ctrl_chk
// attach to every instance of the register block
bind cmcr_ctrl cmcr_ctrl_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .battery_switch_disable_pin_i(battery_switch_disable_pin_i),
    .programming_source_select_o(programming_source_select_o),
    .charger_suspended_o(charger_suspended_o), .charger_restart_o(charger_restart_o),
    .charger_on_o(charger_on_o), .converter_on_o(converter_on_o), .otg_on_o(otg_on_o),
    .battery_switch_on_o(battery_switch_on_o), .input_standby_o(input_standby_o));
`default_nettype wire

// *** cmcr_path_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmcr_path_model (
    input wire logic clock_i,
    input wire logic input_valid_i,
    output logic path_switch_on_o,
    output logic path_converter_on_o
);
// path machine: converter on valid input, else battery switch feeds the rail
always @(posedge clock_i)
begin
    path_converter_on_o <= input_valid_i;
    path_switch_on_o <= !input_valid_i;
end
endmodule // cmcr_path_model
`default_nettype wire

// *** test_charger_mode_control_register.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_charger_mode_control_register;
logic clock_i = 0, rst_i = 1, we = 0, re = 0, pin = 0, fault = 0, valid = 1;
logic [7:0] addr = 0, wd = 0, rdata, rv;
logic pss, susp, rsp, chg, conv, otg, bsw, stby, wdx, psw, pcv;
int err_count = 0, checks = 0, cyc = 0, i;
initial forever #20 clock_i = ~clock_i;
cmcr_path_model path_u (.clock_i(clock_i), .input_valid_i(valid),
    .path_switch_on_o(psw), .path_converter_on_o(pcv));
// short watchdog period keeps the run brief
cmcr_ctrl #(.WD_PERIOD(32'd50)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(we),
    .rd_en_i(re), .addr_i(addr), .wdata_i(wd), .battery_switch_disable_pin_i(pin),
    .resistor_fault_i(fault), .input_valid_i(valid), .path_switch_on_i(psw),
    .path_converter_on_i(pcv), .rdata_o(rdata), .programming_source_select_o(pss),
    .charger_suspended_o(susp), .charger_restart_o(rsp), .charger_on_o(chg),
    .converter_on_o(conv), .otg_on_o(otg), .battery_switch_on_o(bsw),
    .input_standby_o(stby), .watchdog_expired_o(wdx));
// --
// access tasks
// --
task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
        err_count++;
        $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    we = 1;
    addr = a;
    wd = d;
    @(negedge clock_i);
    we = 0;
endtask
// read data is registered at the taking edge, so sample one negedge later
task rd(input logic [7:0] a);
    @(negedge clock_i);
    re = 1;
    addr = a;
    @(negedge clock_i);
    re = 0;
    rv = rdata;
endtask
task finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// hang guard
always @(posedge clock_i)
begin
    cyc++;
    if (cyc == 6000)
    begin
        err_count++;
        finish_test;
    end
end
// --
// scenarios
// --
initial
begin
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 0;
    rd(8'h16);
    chk("reset", rv, 8'h05);
    fault = 1;
    repeat (4) @(negedge clock_i);
    chk("susp", {7'h0, susp}, 8'h01);
    wr(8'h16, 8'h85);
    chk("restart", {7'h0, rsp}, 8'h01);
    repeat (3) @(negedge clock_i);
    chk("resume", {7'h0, susp}, 8'h00);
    chk("pss", {7'h0, pss}, 8'h01);
    wr(8'h16, 8'h05);
    rd(8'h16);
    chk("src", rv, 8'h85);
    // every defined mode code; reserved codes are never written
    for (i = 0; i < 11; i++)
    begin
        if (i == 8)
            i = 10;
        wr(8'h16, 8'h80 | i[7:0]);
        repeat (2) @(negedge clock_i);
        chk("chg", {7'h0, chg}, {7'h0, i > 4 && i < 8});
        chk("otg", {7'h0, otg}, {7'h0, i == 10});
        chk("conv", {7'h0, conv}, {7'h0, i > 3 && i < 8});
        chk("bsw", {7'h0, bsw}, {7'h0, i < 4 || i == 10});
    end
    chk("bsw", {7'h0, bsw}, 8'h01);
    pin = 1;
    repeat (5) @(negedge clock_i);
    chk("bsw", {7'h0, bsw}, 8'h00);
    rd(8'h16);
    chk("dis", {7'h0, rv[6]}, 8'h01);
    pin = 0;
    wr(8'h16, 8'ha5);
    repeat (2) @(negedge clock_i);
    chk("stby", {7'h0, stby}, 8'h01);
    chk("conv", {7'h0, conv}, 8'h00);
    rd(8'h16);
    chk("stbyrd", {7'h0, rv[5]}, 8'h01);
    rd(8'h20);
    chk("unmapped", rv, 8'h00);
    wr(8'h16, 8'h95);
    repeat (3)
    begin
        repeat (30) @(negedge clock_i);
        wr(8'h17, 8'h01);
    end
    chk("wdok", {7'h0, wdx}, 8'h00);
    chk("wdrun", {7'h0, chg}, 8'h01);
    repeat (60) @(negedge clock_i);
    chk("wdexp", {7'h0, wdx}, 8'h01);
    chk("wdchg", {7'h0, chg}, 8'h00);
    rd(8'h16);
    chk("mode", {4'h0, rv[3:0]}, 8'h00);
    finish_test;
end
endmodule // test_charger_mode_control_register
`default_nettype wire
